// [hw/reset_wakeup_supervisor.sv]
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module reset_wakeup_supervisor
	import rws_pkg::*;
(
	// Clock and reset.
	input  wire logic              clk,
	input  wire logic              rst,
	// Register port.
	input  wire bus_req_t          bus,
	output logic [DATA_W-1:0]      rdata,
	// Monitors and pins.
	input  wire pins_t             pins,
	// Reset and power control.
	output logic                   device_reset,
	output logic                   cpu_enable,
	output logic [1:0]             power_mode,
	output logic                   main_internal_oscillator_en,
	output logic [2:0]             monitor_irq,
	output logic [3:0]             alv_trip_level,
	output logic [3:0]             dlv_trip_level,
	// Boost converter.
	output logic [1:0]             boost_freq,
	output logic                   boost_xtal_select,
	output logic                   boost_standby,
	output logic                   boost_pulse
);

	st_t st_q;
	st_t st_d;

	logic       initial_power_on_reset_act;
	logic       run_mode;
	logic       mon_on;
	logic       precise_voltage_reset_trip;
	logic [2:0] mon_trip;
	logic       alv_rst;
	logic       dlv_rst;
	logic       external_reset_n_act;
	logic       wdog_fire;
	logic       src_any;
	logic [3:0] wake_vec;
	logic       wake;
	logic       xtal_edge;
	logic       ctrl_wr;
	logic [7:0] events;

	// Source decode from the synchronised pins; only the second stage is read.
	always_comb
	begin
		initial_power_on_reset_act  = st_q.s2.initial_power_on_reset && !st_q.initial_power_on_reset_done;
		run_mode  = (st_q.mode == PM_ACTIVE) || (st_q.mode == PM_ALT);
		mon_on    = run_mode || ((st_q.mode == PM_SLEEP) && st_q.s2.buzz);
		precise_voltage_reset_trip = mon_on && (st_q.s2.precise_voltage_reset_dig
			|| (st_q.s2.precise_voltage_reset_ana && st_q.s2.analog_reg_en));
		mon_trip  = {st_q.s2.analog_high_volt_irq, st_q.s2.digital_low_volt_irq,
			st_q.s2.analog_low_volt_irq} & {3{st_q.mon_en && mon_on}};
		alv_rst   = mon_trip[0] && st_q.alv_rst_sel;
		dlv_rst   = mon_trip[1] && st_q.dlv_rst_sel;
		external_reset_n_act  = !st_q.s2.external_reset_n;
		wdog_fire = st_q.wdog_en && (st_q.wdog_cnt == st_q.wdog_time);
		src_any   = initial_power_on_reset_act || precise_voltage_reset_trip || external_reset_n_act || wdog_fire || st_q.sw_req
			|| alv_rst || dlv_rst;
		wake_vec  = st_q.s2.wake_irq;
		wake_vec[WAKE_SUPERVISOR] = st_q.s2.wake_irq[WAKE_SUPERVISOR] | (|st_q.mon_pend);
		wake      = (|(wake_vec & st_q.wake_en)) || src_any;
		xtal_edge = st_q.s2.xtal_clk ^ st_q.xtal_prev;
		ctrl_wr   = bus.we && (bus.addr == OFS_CTRL) && !st_q.dev_rst;
		events    = '0;
		events[CAUSE_PRECISE] = precise_voltage_reset_trip;
		events[CAUSE_EXT]     = external_reset_n_act;
		events[CAUSE_WDOG]    = wdog_fire;
		events[CAUSE_SW]      = st_q.sw_req;
		events[CAUSE_ALV]     = mon_trip[0];
		events[CAUSE_DLV]     = mon_trip[1];
		events[CAUSE_AHV]     = mon_trip[2];
	end

	// Next-state logic for the whole block.
	always_comb
	begin
		st_d = st_q;
		st_d.s1 = pins;
		st_d.s2 = st_q.s1;
		st_d.xtal_prev = st_q.s2.xtal_clk;
		st_d.sw_req = 1'b0;

		// Hand over once supply stable.
		// A collapsed supply re-arms the initial monitor for the next power-on.
		if (!st_q.s2.vddd_stable)
			st_d.initial_power_on_reset_done = 1'b0;
		else if (!st_q.s2.initial_power_on_reset)
			st_d.initial_power_on_reset_done = 1'b1;
		st_d.mon_en = st_q.initial_power_on_reset_done;
		st_d.osc_en = st_q.initial_power_on_reset_done && !st_q.s2.precise_voltage_reset_dig;

		if (src_any)
		begin
			st_d.dev_rst = 1'b1;
			st_d.rst_cnt = '0;
		end
		else if (st_q.dev_rst)
		begin
			if (st_q.rst_cnt == RST_CNT_W'(MIN_RESET_CYC - 1))
				st_d.dev_rst = 1'b0;
			else
				st_d.rst_cnt = st_q.rst_cnt + 1'b1;
		end

		if (initial_power_on_reset_act)
			st_d.cause = '0;
		else if (|events)
			st_d.cause = events;

		if (initial_power_on_reset_act)
			st_d.wdog_en = 1'b0;

		if (!st_q.wdog_en || st_q.dev_rst || (ctrl_wr && bus.wdata[CTRL_WDOG_KICK]))
		begin
			st_d.wdog_tick = '0;
			st_d.wdog_cnt  = '0;
		end
		else if (st_q.wdog_tick == 8'(WDOG_TICK_CYC - 1))
		begin
			st_d.wdog_tick = '0;
			st_d.wdog_cnt  = st_q.wdog_cnt + 1'b1;
		end
		else
			st_d.wdog_tick = st_q.wdog_tick + 1'b1;

		// Pending monitor interrupts shown only after wakeup.
		st_d.mon_pend = (st_q.mon_pend & {3{!run_mode}})
			| (mon_trip & ~{1'b0, st_q.dlv_rst_sel, st_q.alv_rst_sel});
		st_d.mon_irq = st_q.mon_pend & {3{run_mode}};

		// Register writes; the processor is held off while reset stands.
		if (bus.we && !st_q.dev_rst)
		begin
			case (bus.addr)
				OFS_CTRL:
				begin
					st_d.sw_req = bus.wdata[CTRL_SW_RESET] && !st_q.sw_dis;
					st_d.sw_dis = bus.wdata[CTRL_SW_DIS];
					st_d.wdog_en = st_q.wdog_en | bus.wdata[CTRL_WDOG_EN];
					st_d.alv_rst_sel = bus.wdata[CTRL_ALV_RST];
					st_d.dlv_rst_sel = bus.wdata[CTRL_DLV_RST];
					if (bus.wdata[CTRL_CPU_OFF])
						st_d.cpu_en = 1'b0;
				end
				OFS_WDOG_TIME: st_d.wdog_time = bus.wdata;
				OFS_BOOST:
				begin
					st_d.bfreq = boost_freq_t'(bus.wdata[1:0]);
					st_d.bstby = bus.wdata[BOOST_STBY];
				end
				OFS_MODE:
				begin
					if (run_mode)
						st_d.mode = pmode_t'(bus.wdata[1:0]);
				end
				OFS_WAKE_EN: st_d.wake_en = bus.wdata[3:0];
				OFS_LVL:
				begin
					st_d.alv_lvl = bus.wdata[3:0];
					st_d.dlv_lvl = bus.wdata[LVL_DLV_LSB +: 4];
				end
				default: ;
			endcase
		end

		case (st_q.mode)
			PM_ACTIVE, PM_ALT, PM_SLEEP, PM_HIBERNATE:
			begin
				if (wake)
				begin
					st_d.mode = PM_ACTIVE;
					st_d.cpu_en = 1'b1;
				end
			end
			default: st_d.mode = PM_ACTIVE;
		endcase

		// Device reset clears the processor-side registers, except the watchdog enable, the cause register and the boost settings.
		if (st_q.dev_rst)
		begin
			st_d.sw_dis      = 1'b0;
			st_d.alv_rst_sel = 1'b0;
			st_d.dlv_rst_sel = 1'b0;
			st_d.wdog_time   = WDOG_TIME_RST;
			st_d.wake_en     = WAKE_EN_RST;
			st_d.alv_lvl     = LVL_RST;
			st_d.dlv_lvl     = LVL_RST;
			st_d.mode        = PM_ACTIVE;
			st_d.cpu_en      = 1'b1;
		end

		st_d.bstby_out = st_q.bstby && (st_q.mode != PM_HIBERNATE);
		st_d.bpulse = xtal_edge && (st_q.bfreq == BF_32K) && st_q.bstby_out
			&& st_q.s2.boost_below;

		// Read data stands only in the cycle after the read strobe.
		st_d.rdata = '0;
		if (bus.re)
		begin
			case (bus.addr)
				OFS_CTRL:
				begin
					st_d.rdata[CTRL_SW_DIS]  = st_q.sw_dis;
					st_d.rdata[CTRL_WDOG_EN] = st_q.wdog_en;
					st_d.rdata[CTRL_ALV_RST] = st_q.alv_rst_sel;
					st_d.rdata[CTRL_DLV_RST] = st_q.dlv_rst_sel;
					st_d.rdata[CTRL_CPU_OFF] = !st_q.cpu_en;
				end
				OFS_WDOG_TIME: st_d.rdata = st_q.wdog_time;
				OFS_CAUSE:     st_d.rdata = st_q.cause;
				OFS_BOOST:     st_d.rdata = {5'h00, st_q.bstby, st_q.bfreq};
				OFS_MODE:      st_d.rdata = {6'h00, st_q.mode};
				OFS_WAKE_EN:   st_d.rdata = {4'h0, st_q.wake_en};
				OFS_LVL:       st_d.rdata = {st_q.dlv_lvl, st_q.alv_lvl};
				default:       st_d.rdata = '0;
			endcase
		end
	end

	// State register; reset values are constants only.
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			st_q <= '0;
			st_q.s1.external_reset_n <= 1'b1;
			st_q.s2.external_reset_n <= 1'b1;
			st_q.dev_rst <= 1'b1;
			st_q.cpu_en <= 1'b1;
			st_q.wdog_time <= WDOG_TIME_RST;
			st_q.wake_en <= WAKE_EN_RST;
		end
		else
			st_q <= st_d;
	end

	// Outputs come straight from the state register; the crystal select is decoded from the boost rate.
	assign rdata                       = st_q.rdata;
	assign device_reset                = st_q.dev_rst;
	assign cpu_enable                  = st_q.cpu_en;
	assign power_mode                  = st_q.mode;
	assign main_internal_oscillator_en = st_q.osc_en;
	assign monitor_irq                 = st_q.mon_irq;
	assign alv_trip_level              = st_q.alv_lvl;
	assign dlv_trip_level              = st_q.dlv_lvl;
	assign boost_freq                  = st_q.bfreq;
	assign boost_xtal_select           = (st_q.bfreq == BF_32K);
	assign boost_standby               = st_q.bstby_out;
	assign boost_pulse                 = st_q.bpulse;

	// Checks on the block's own behaviour.
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	a_ext_reset_hold: assert property (external_reset_n_act |=> device_reset)
		else $error("external reset low did not hold device reset");

	a_reset_min_width: assert property (
		(st_q.dev_rst && !st_d.dev_rst) |-> st_q.rst_cnt == RST_CNT_W'(MIN_RESET_CYC - 1))
		else $error("device reset released before minimum width");

	a_wdog_sticky: assert property ((st_q.wdog_en && !initial_power_on_reset_act) |=> st_q.wdog_en)
		else $error("watchdog enable cleared without power-on");

	a_wdog_timeout: assert property (wdog_fire |=> device_reset)
		else $error("watchdog timeout did not reset");

	a_wake_to_active: assert property (
		(st_q.mode == PM_SLEEP && wake && !st_q.dev_rst) |=> (power_mode == PM_ACTIVE && cpu_enable))
		else $error("wakeup did not return to active");

	a_sw_reset_go: assert property (
		(ctrl_wr && bus.wdata[CTRL_SW_RESET] && !st_q.sw_dis) |=> ##1 device_reset)
		else $error("software reset bit did not reset");

	a_sw_reset_off: assert property ((ctrl_wr && st_q.sw_dis) |=> !st_q.sw_req)
		else $error("disabled software reset still fired");

	a_hib_boost: assert property (
		(power_mode == PM_HIBERNATE && $past(power_mode) == PM_HIBERNATE) |-> !boost_standby)
		else $error("boost standby in hibernate");

	a_pulse_xtal: assert property (boost_pulse |-> $past(st_q.bfreq) == BF_32K)
		else $error("boost pulse outside crystal rate");

	a_cause_clear: assert property (initial_power_on_reset_act |=> st_q.cause == 8'h00)
		else $error("cause not cleared by power-on");

	a_sleep_irq_hold: assert property ((st_q.mode == PM_SLEEP) |=> monitor_irq == 3'h0)
		else $error("monitor interrupt raised while asleep");

	c_wake_sleep: cover property (st_q.mode == PM_SLEEP ##1 st_q.mode == PM_ACTIVE);
	c_wdog_fire: cover property (wdog_fire);
	c_ext_reset: cover property (external_reset_n_act ##[1:20] !device_reset);
	c_pulse: cover property (boost_pulse);

endmodule : reset_wakeup_supervisor
`default_nettype wire

// [pkg/rws_pkg.sv]
// Operation
// - An enabled wakeup event returns the global power mode to active.
// - Wake interrupts: peripherals, power supervisor, periodic timewheel and pin interrupts.
// - Reset wake sources: external reset pin, watchdog and precise voltage monitor.
// - Boost switching clock selects one of four rates.
// - The lowest boost rate takes its clock from the watch crystal.
// - Boost has an active regulating mode and a low-power standby mode.
// - Crystal pulse mode fires a pulse on each crystal edge while output is low.
// - In hibernate only active boost mode; sleep allows either.
// - A supply leaving its range resets; monitors may interrupt beforehand.
// - Device reset clears processor, peripherals and their registers.
// - Status register keeps the last reset or monitor cause; power-on clears it.
// - Initial power-on reset pulse is at least the minimum width.
// - Stable digital supply hands over to precise monitor; oscillator starts after release.
// - Precise monitor acts as power-on reset; digital part cannot be disabled.
// - Precise monitor is off in sleep and hibernate except during buzz; the code turns it on for buzz in sleep only, never in hibernate.
// - Low-voltage monitors have stepped programmable trip levels; high monitor is fixed.
// - Each low-voltage monitor can cause a reset instead of an interrupt.
// - Monitors wait for power-on end; buzz interrupts are seen after wakeup.
// - External reset held low keeps the device in reset, in every mode.
// - Setting the software reset bit resets the device unless disabled.
// - A watchdog not restarted within its timeout resets the device.
// - Power-on disables the watchdog; its enable is sticky until power-on.
// - Every wakeup event re-enables the processor.
package rws_pkg;

	// Register port widths.
	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;

	// Register offsets.
	localparam logic [ADDR_W-1:0] OFS_CTRL      = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_WDOG_TIME = 4'h1;
	localparam logic [ADDR_W-1:0] OFS_CAUSE     = 4'h2;
	localparam logic [ADDR_W-1:0] OFS_BOOST     = 4'h3;
	localparam logic [ADDR_W-1:0] OFS_MODE      = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_WAKE_EN   = 4'h5;
	localparam logic [ADDR_W-1:0] OFS_LVL       = 4'h6;

	// Control register bits.
	localparam int CTRL_SW_RESET  = 0;
	localparam int CTRL_SW_DIS    = 1;
	localparam int CTRL_WDOG_EN   = 2;
	localparam int CTRL_WDOG_KICK = 3;
	localparam int CTRL_ALV_RST   = 4;
	localparam int CTRL_DLV_RST   = 5;
	localparam int CTRL_CPU_OFF   = 6;

	// Cause register bits.
	localparam int CAUSE_PRECISE = 1;
	localparam int CAUSE_EXT     = 2;
	localparam int CAUSE_WDOG    = 3;
	localparam int CAUSE_SW      = 4;
	localparam int CAUSE_ALV     = 5;
	localparam int CAUSE_DLV     = 6;
	localparam int CAUSE_AHV     = 7;

	// Field positions.
	localparam int BOOST_STBY = 2;
	localparam int LVL_DLV_LSB = 4;
	localparam int WAKE_SUPERVISOR = 1;

	// Reset values.
	localparam logic [7:0] WDOG_TIME_RST = 8'hff;
	localparam logic [3:0] WAKE_EN_RST   = 4'hf;
	localparam logic [3:0] LVL_RST       = 4'h0;

	// Timing.
	localparam int CLK_PERIOD_NS = 8;
	localparam int MIN_RESET_NS  = 100;
	localparam int MIN_RESET_CYC = (MIN_RESET_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int RST_CNT_W     = 4;
	localparam int WDOG_TICK_CYC = 256;

	typedef enum logic [1:0] {
		PM_ACTIVE    = 2'b00,
		PM_ALT       = 2'b01,
		PM_SLEEP     = 2'b10,
		PM_HIBERNATE = 2'b11
	} pmode_t;

	typedef enum logic [1:0] {
		BF_100K = 2'b00,
		BF_400K = 2'b01,
		BF_2M   = 2'b10,
		BF_32K  = 2'b11
	} boost_freq_t;

	// Asynchronous inputs from the analog monitors and pins.
	typedef struct packed {
		logic       initial_power_on_reset;
		logic       precise_voltage_reset_dig;
		logic       precise_voltage_reset_ana;
		logic       analog_reg_en;
		logic       vddd_stable;
		logic       analog_low_volt_irq;
		logic       digital_low_volt_irq;
		logic       analog_high_volt_irq;
		logic       external_reset_n;
		logic       buzz;
		logic       xtal_clk;
		logic       boost_below;
		logic [3:0] wake_irq;
	} pins_t;

	// Register port request, same clock domain.
	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic [DATA_W-1:0] wdata;
		logic              we;
		logic              re;
	} bus_req_t;

	// Whole state of the supervisor.
	typedef struct packed {
		pins_t                s1;
		pins_t                s2;
		logic                 xtal_prev;
		logic                 initial_power_on_reset_done;
		logic                 mon_en;
		logic [RST_CNT_W-1:0] rst_cnt;
		logic                 dev_rst;
		logic                 osc_en;
		pmode_t               mode;
		logic                 cpu_en;
		logic                 sw_dis;
		logic                 sw_req;
		logic                 wdog_en;
		logic [7:0]           wdog_time;
		logic [7:0]           wdog_tick;
		logic [7:0]           wdog_cnt;
		logic                 alv_rst_sel;
		logic                 dlv_rst_sel;
		logic [3:0]           alv_lvl;
		logic [3:0]           dlv_lvl;
		logic [7:0]           cause;
		boost_freq_t          bfreq;
		logic                 bstby;
		logic                 bstby_out;
		logic                 bpulse;
		logic [3:0]           wake_en;
		logic [2:0]           mon_pend;
		logic [2:0]           mon_irq;
		logic [DATA_W-1:0]    rdata;
	} st_t;

endpackage : rws_pkg

// [test/supply_side_model.sv]
`timescale 1ns/1ps
`default_nettype none
module supply_side_model
	import rws_pkg::*;
#(
	parameter int XTAL_HALF = 20
)
(
	// Clock.
	input  wire logic       clk,
	// Commands from the bench.
	input  wire logic       por,
	input  wire logic       precise_voltage_reset,
	input  wire logic       external_reset_n_hold,
	input  wire logic [2:0] trip,
	input  wire logic       below,
	input  wire logic [3:0] wake,
	// Pins seen by the supervisor.
	output var  pins_t      pins
);
	logic [7:0] xcnt = 8'h00;
	logic       xtal = 1'b0;

	// The crystal is far slower than the system clock, so a divided tick stands in for it.
	always @(posedge clk)
	begin
		xcnt <= (xcnt == 8'(XTAL_HALF - 1)) ? 8'h00 : xcnt + 8'h01;
		if (xcnt == 8'(XTAL_HALF - 1))
			xtal <= ~xtal;
	end

	// Pin levels follow the commands.
	always_comb
	begin
		pins = '0;
		pins.initial_power_on_reset = por;
		pins.vddd_stable = ~por;
		pins.precise_voltage_reset_dig = precise_voltage_reset;
		pins.analog_reg_en = 1'b1;
		pins.external_reset_n = ~external_reset_n_hold;
		{pins.analog_high_volt_irq, pins.digital_low_volt_irq, pins.analog_low_volt_irq} = trip;
		pins.xtal_clk = xtal;
		pins.boost_below = below;
		pins.wake_irq = wake;
	end
endmodule : supply_side_model
`default_nettype wire

// [test/reset_wakeup_supervisor_bench.sv]
`timescale 1ns/1ps
`default_nettype none
module reset_wakeup_supervisor_bench
	import rws_pkg::*;
;
	logic              clk;
	logic              rst;
	bus_req_t          bus;
	pins_t             pins;
	logic [DATA_W-1:0] rdata;
	logic              device_reset;
	logic              cpu_enable;
	logic [1:0]        power_mode;
	logic              osc_en;
	logic [2:0]        monitor_irq;
	logic [1:0]        boost_freq;
	logic              xtal_sel;
	logic              boost_standby;
	logic              boost_pulse;
	logic              por;
	logic              precise_voltage_reset;
	logic              external_reset_n_hold;
	logic              below;
	logic [2:0]        trip;
	logic [3:0]        wake;
	logic [7:0]        d;
	int                n;
	int                error_cnt;
	int                total_checks;

	reset_wakeup_supervisor dut (
		.clk(clk), .rst(rst), .bus(bus), .rdata(rdata), .pins(pins),
		.device_reset(device_reset), .cpu_enable(cpu_enable), .power_mode(power_mode),
		.main_internal_oscillator_en(osc_en), .monitor_irq(monitor_irq),
		.alv_trip_level(), .dlv_trip_level(), .boost_freq(boost_freq),
		.boost_xtal_select(xtal_sel), .boost_standby(boost_standby), .boost_pulse(boost_pulse)
	);

	supply_side_model far (
		.clk(clk), .por(por), .precise_voltage_reset(precise_voltage_reset), .external_reset_n_hold(external_reset_n_hold), .trip(trip),
		.below(below), .wake(wake), .pins(pins)
	);

	// Free-running system clock.
	always #4 clk = ~clk;

	task automatic give_verdict;
		if (error_cnt == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask : give_verdict

	task automatic chk(input logic ok, input string msg);
		total_checks++;
		if (ok !== 1'b1)
		begin
			error_cnt++;
			$display("wrong value at %0t: %s", $time, msg);
		end
	endtask : chk

	task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] v);
		@(posedge clk);
		bus.addr <= a;
		bus.wdata <= v;
		bus.we <= 1'b1;
		@(posedge clk);
		bus.we <= 1'b0;
		#1;
	endtask : wr

	// Read data stand only in the cycle after the strobe, so they are taken right there.
	task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] v);
		@(posedge clk);
		bus.addr <= a;
		bus.re <= 1'b1;
		@(posedge clk);
		bus.re <= 1'b0;
		#1;
		v = rdata;
	endtask : rd

	task automatic wait_rst(input logic v, input int lim, input string msg);
		int i;
		i = 0;
		do
		begin
			@(posedge clk);
			#1;
			i++;
		end
		while (device_reset !== v && i < lim);
		chk(device_reset === v, msg);
	endtask : wait_rst

	task automatic pulse_wake(input int i);
		@(posedge clk);
		wake <= 4'(1 << i);
		repeat (6) @(posedge clk);
		wake <= 4'h0;
		repeat (4) @(posedge clk);
		#1;
	endtask : pulse_wake

	task automatic count_pulses(input int cyc, output int k);
		k = 0;
		repeat (cyc)
		begin
			@(posedge clk);
			#1;
			if (boost_pulse === 1'b1)
				k++;
		end
	endtask : count_pulses

	task automatic t_boot;
		wait_rst(1'b0, 100, "reset not released");
		chk(cpu_enable === 1'b1 && power_mode === PM_ACTIVE, "boot state");
		chk(osc_en === 1'b1, "oscillator off");
		rd(OFS_WDOG_TIME, d);
		chk(d === WDOG_TIME_RST, "timeout reset value");
		rd(4'hf, d);
		chk(d === 8'h00, "unmapped read");
	endtask : t_boot

	task automatic t_boost;
		for (int f = 0; f < 4; f++)
		begin
			wr(OFS_BOOST, 8'(f));
			chk(boost_freq === 2'(f), "boost rate");
			chk(xtal_sel === (f == 3), "crystal select");
		end
		wr(OFS_BOOST, 8'h07);
		@(posedge clk);
		#1;
		chk(boost_standby === 1'b1, "standby");
		@(posedge clk);
		below <= 1'b1;
		count_pulses(200, n);
		chk(n >= 9 && n <= 11, "pulse count");
		@(posedge clk);
		below <= 1'b0;
		repeat (6) @(posedge clk);
		count_pulses(100, n);
		chk(n == 0, "pulse while above");
	endtask : t_boost

	task automatic t_wake;
		wr(OFS_CTRL, 8'h40);
		chk(cpu_enable === 1'b0, "cpu off");
		wr(OFS_MODE, 8'(PM_ALT));
		chk(power_mode === PM_ALT, "alternate active entry");
		for (int i = 0; i < 4; i++)
		begin
			wr(OFS_MODE, 8'(PM_SLEEP));
			chk(power_mode === PM_SLEEP, "sleep entry");
			pulse_wake(i);
			chk(power_mode === PM_ACTIVE && cpu_enable === 1'b1, "wake");
		end
		wr(OFS_BOOST, 8'h04);
		wr(OFS_MODE, 8'(PM_HIBERNATE));
		@(posedge clk);
		#1;
		chk(power_mode === PM_HIBERNATE && boost_standby === 1'b0, "hibernate boost");
		pulse_wake(3);
		chk(power_mode === PM_ACTIVE && boost_standby === 1'b1, "hibernate wake");
	endtask : t_wake

	task automatic t_ext;
		wr(OFS_WAKE_EN, 8'h00);
		@(posedge clk);
		external_reset_n_hold <= 1'b1;
		wait_rst(1'b1, 5, "external reset");
		repeat (40) @(posedge clk);
		#1;
		chk(device_reset === 1'b1, "external held");
		@(posedge clk);
		external_reset_n_hold <= 1'b0;
		wait_rst(1'b0, 30, "external release");
		rd(OFS_CAUSE, d);
		chk(d[CAUSE_EXT] === 1'b1, "cause external");
		rd(OFS_WAKE_EN, d);
		chk(d[3:0] === WAKE_EN_RST, "register not cleared");
	endtask : t_ext

	task automatic t_sw;
		wr(OFS_CTRL, 8'h01);
		wait_rst(1'b1, 5, "software reset");
		wait_rst(1'b0, 30, "software release");
		rd(OFS_CAUSE, d);
		chk(d[CAUSE_SW] === 1'b1, "cause software");
		wr(OFS_CTRL, 8'h02);
		wr(OFS_CTRL, 8'h03);
		repeat (5) @(posedge clk);
		#1;
		chk(device_reset === 1'b0, "software reset disabled");
	endtask : t_sw

	task automatic t_monitor;
		@(posedge clk);
		trip <= 3'b001;
		repeat (6) @(posedge clk);
		#1;
		chk(monitor_irq[0] === 1'b1 && device_reset === 1'b0, "low volt irq");
		@(posedge clk);
		trip <= 3'b000;
		wr(OFS_CTRL, 8'h10);
		@(posedge clk);
		trip <= 3'b001;
		wait_rst(1'b1, 8, "low volt reset");
		@(posedge clk);
		trip <= 3'b000;
		wait_rst(1'b0, 30, "low volt release");
		rd(OFS_CAUSE, d);
		chk(d[CAUSE_ALV] === 1'b1, "cause low volt");
		@(posedge clk);
		precise_voltage_reset <= 1'b1;
		wait_rst(1'b1, 8, "precise reset");
		@(posedge clk);
		precise_voltage_reset <= 1'b0;
		wait_rst(1'b0, 30, "precise release");
		rd(OFS_CAUSE, d);
		chk(d[CAUSE_PRECISE] === 1'b1, "cause precise");
	endtask : t_monitor

	task automatic t_wdog;
		wr(OFS_WDOG_TIME, 8'h02);
		wr(OFS_CTRL, 8'h04);
		repeat (3)
		begin
			repeat (300) @(posedge clk);
			wr(OFS_CTRL, 8'h0c);
		end
		chk(device_reset === 1'b0, "restarted watchdog fired");
		wait_rst(1'b1, 800, "watchdog reset");
		wait_rst(1'b0, 30, "watchdog release");
		rd(OFS_CAUSE, d);
		chk(d[CAUSE_WDOG] === 1'b1, "cause watchdog");
		wr(OFS_WDOG_TIME, 8'h01);
		wait_rst(1'b1, 700, "watchdog not sticky");
		wait_rst(1'b0, 30, "watchdog release");
		@(posedge clk);
		por <= 1'b1;
		wait_rst(1'b1, 5, "power-on reset");
		repeat (20) @(posedge clk);
		por <= 1'b0;
		wait_rst(1'b0, 100, "power-on release");
		rd(OFS_CAUSE, d);
		chk(d === 8'h00, "cause not cleared");
		wr(OFS_WDOG_TIME, 8'h01);
		repeat (700) @(posedge clk);
		#1;
		chk(device_reset === 1'b0, "watchdog still on");
	endtask : t_wdog

	// Main sequence; the power-on pulse outlasts the reset so monitors start clean.
	initial
	begin
		clk = 1'b0;
		rst = 1'b1;
		bus = '0;
		por = 1'b1;
		precise_voltage_reset = 1'b0;
		external_reset_n_hold = 1'b0;
		trip = 3'b000;
		below = 1'b0;
		wake = 4'h0;
		error_cnt = 0;
		total_checks = 0;
		repeat (12) @(posedge clk);
		rst <= 1'b0;
		repeat (20) @(posedge clk);
		por <= 1'b0;
		t_boot;
		t_boost;
		t_wake;
		t_ext;
		t_sw;
		t_monitor;
		t_wdog;
		give_verdict;
	end

	// Hang guard, well beyond the few thousand cycles the sequence needs.
	initial
	begin
		#(CLK_PERIOD_NS * 20000);
		error_cnt++;
		give_verdict;
	end
endmodule : reset_wakeup_supervisor_bench
`default_nettype wire
